// ===== core/temp_sensor_smbus_core.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_smbus_core
  import temp_sensor_pkg::*;
#(
  parameter int LOCKUP_LIMIT = LOCKUP_CYCLES,
  parameter int CONV_CYCLES = CONV_BASE_CYCLES,
  parameter bit ADDR_VARIANT = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] addr_pin_i,
  input wire logic [15:0] sample_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o
);

  conv_if conv ();

  logic scl_f, sda_f, scl_q, sda_q;
  logic [1:0] line_raw, line_flt;
  logic [1:0] pin_s1, pin_s2;
  logic shutdown, next_shutdown;
  logic [1:0] res, next_res;
  logic data_available_flag, next_dav;
  logic [15:0] result, next_result;
  logic one_shot_req, next_one_shot_req;
  logic in_one_shot, next_in_one_shot;
  logic os_running, next_os_running;
  logic start, next_start;
  logic [IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
  logic [IRQ_WIDTH-1:0] events;
  logic [15:0] rdata, next_rdata;
  logic irq, next_irq;
  bus_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [15:0] tx_word, next_tx_word;
  logic byte_sel, next_byte_sel;
  logic rw, next_rw;
  logic nack, next_nack;
  logic drive, next_drive;
  logic [23:0] lockup_cnt, next_lockup_cnt;
  logic lockup;
  logic addr_hit;
  logic [6:0] own_addr;
  logic [1:0] addr_sel;
  logic [15:0] res_mask;
  logic [15:0] shown_result;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic cfg_write, ctl_write;

  // Both bus lines pass a synchroniser and a glitch filter
  for (genvar i = 0; i < 2; i++) begin : g_filter
    line_filter #(
      .STABLE(GLITCH_CYCLES)
    ) u_filter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .line_i(line_raw[i]),
      .line_o(line_flt[i])
    );
  end
  // Index 0 carries the bus clock, index 1 the data line
  assign line_raw = {sda_i, scl_i};
  assign scl_f = line_flt[0];
  assign sda_f = line_flt[1];

  conv_unit #(
    .BASE_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sample_i(sample_i),
    .conv(conv)
  );

  // Strap pin is a slow level; two flops are enough
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_s1 <= PIN_FLOAT;
      pin_s2 <= PIN_FLOAT;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      pin_s1 <= addr_pin_i;
      pin_s2 <= pin_s1;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Pin level picks one of three addresses inside the variant's group
  always_comb begin
    case (pin_s2)
      PIN_GROUND: addr_sel = 2'h1;
      PIN_SUPPLY: addr_sel = 2'h2;
      default: addr_sel = 2'h0;
    endcase
  end
  assign own_addr = {ADDR_PREFIX, ADDR_VARIANT, addr_sel};

  // Bus events from the filtered lines; the clock is only ever sampled
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  assign start_cond = scl_f && scl_q && sda_q && !sda_f;
  assign stop_cond = scl_f && scl_q && !sda_q && sda_f;

  // Mask of the bits kept at the chosen resolution
  assign res_mask = ~(LOW_BITS_11 >> res);
  assign shown_result = result & res_mask;

  // Lockup watch: either line low too long, counted once per episode
  always_comb begin
    next_lockup_cnt = 24'h00_0000;
    lockup = 1'b0;
    if (!scl_f || !sda_f) begin
      next_lockup_cnt = lockup_cnt;
      if (lockup_cnt < 24'(LOCKUP_LIMIT)) begin
        next_lockup_cnt = lockup_cnt + 24'h00_0001;
      end
      lockup = (lockup_cnt == 24'(LOCKUP_LIMIT - 1));
    end
  end

  // Slave protocol; it drives data low only for ack and read zeros
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx_word = tx_word;
    next_byte_sel = byte_sel;
    next_rw = rw;
    next_nack = nack;
    next_drive = drive;
    addr_hit = 1'b0;
    if (lockup) begin
      next_state = BUS_IDLE;
      next_drive = 1'b0;
    end else if (stop_cond) begin
      next_state = BUS_IDLE;
      next_drive = 1'b0;
    end else if (start_cond) begin
      // A repeated start restarts address reception from any state
      next_state = BUS_ADDR;
      next_bit_cnt = 4'h0;
      next_drive = 1'b0;
    end else begin
      case (state)
        BUS_IDLE: begin
          next_drive = 1'b0;
        end
        BUS_ADDR, BUS_WRITE: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (state == BUS_WRITE) begin
              // Written bytes are acknowledged and discarded
              next_drive = 1'b1;
              next_state = BUS_ACK_WRITE;
            end else if (shreg[7:1] == own_addr) begin
              addr_hit = 1'b1;
              next_drive = 1'b1;
              next_rw = shreg[0];
              next_tx_word = shown_result;
              next_byte_sel = 1'b0;
              next_state = BUS_ACK_ADDR;
            end else begin
              next_state = BUS_IDLE;
            end
          end
        end
        BUS_ACK_ADDR, BUS_ACK_WRITE: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (state == BUS_ACK_ADDR && rw) begin
              next_shreg = tx_word[15:8];
              next_drive = !tx_word[15];
              next_state = BUS_READ;
            end else begin
              next_drive = 1'b0;
              next_state = BUS_WRITE;
            end
          end
        end
        BUS_READ: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              next_drive = 1'b0;
              next_state = BUS_ACK_READ;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive = !shreg[6];
            end
          end
        end
        BUS_ACK_READ: begin
          if (scl_rise) begin
            next_nack = sda_f;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (nack) begin
              next_state = BUS_IDLE;
            end else begin
              // Bytes alternate high then low of the latched word
              next_byte_sel = !byte_sel;
              next_shreg = byte_sel ? tx_word[15:8] : tx_word[7:0];
              next_drive = byte_sel ? !tx_word[15] : !tx_word[7];
              next_state = BUS_READ;
            end
          end
        end
        default: begin
          next_state = BUS_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  assign cfg_write = reg_write_i && reg_addr_i == CONFIG_OFFSET;
  assign ctl_write = reg_write_i && reg_addr_i == CONTROL_STATUS_OFFSET;

  // Conversion sequencing, one-shot state and software-written fields
  always_comb begin
    next_shutdown = shutdown;
    next_res = res;
    next_dav = data_available_flag;
    next_result = result;
    next_one_shot_req = one_shot_req;
    next_in_one_shot = in_one_shot;
    next_os_running = os_running;
    next_start = 1'b0;
    if (cfg_write) begin
      next_shutdown = reg_wdata_i[SHUTDOWN_BIT];
    end
    if (ctl_write) begin
      next_res = {reg_wdata_i[RES_HI_BIT], reg_wdata_i[RES_LO_BIT]};
    end
    // Start only from an idle unit so that no request is doubled
    if (!conv.busy && !start && !conv.done) begin
      if (!shutdown) begin
        next_start = 1'b1;
      end else if (one_shot_req) begin
        next_start = 1'b1;
        next_one_shot_req = 1'b0;
        next_os_running = 1'b1;
      end
    end
    if (conv.done) begin
      next_os_running = 1'b0;
      // A conversion left over from before shutdown may not end the
      // one-shot state, or 8000h would vanish too early
      if (!in_one_shot || os_running) begin
        next_result = conv.value;
        next_dav = 1'b1;
        next_in_one_shot = 1'b0;
      end
    end
    if (cfg_write && reg_wdata_i[ONE_SHOT_BIT] && shutdown) begin
      next_one_shot_req = 1'b1;
      next_in_one_shot = 1'b1;
      next_result = RESULT_ONE_SHOT;
      next_dav = 1'b0;
    end
  end

  assign conv.start = start;
  assign conv.res = res;

  // Sticky interrupt bits; a new event beats a clear in the same cycle
  assign events = {addr_hit, lockup, conv.done};
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (reg_write_i && reg_addr_i == IRQ_STATUS_OFFSET) begin
      next_irq_status = irq_status & ~reg_wdata_i[IRQ_WIDTH-1:0];
    end
    if (reg_write_i && reg_addr_i == IRQ_MASK_OFFSET) begin
      next_irq_mask = reg_wdata_i[IRQ_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Read data stand for the one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_read_i) begin
      case (reg_addr_i)
        CONFIG_OFFSET: begin
          next_rdata[SHUTDOWN_BIT] = shutdown;
        end
        CONTROL_STATUS_OFFSET: begin
          next_rdata[RES_HI_BIT] = res[1];
          next_rdata[RES_LO_BIT] = res[0];
          next_rdata[DATA_AVAILABLE_BIT] = data_available_flag;
        end
        RESULT_OFFSET: next_rdata = shown_result;
        IRQ_STATUS_OFFSET: next_rdata[IRQ_WIDTH-1:0] = irq_status;
        IRQ_MASK_OFFSET: next_rdata[IRQ_WIDTH-1:0] = irq_mask;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // The remaining state registers; each takes a fixed value at reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shutdown <= 1'b0;
      res <= RES_RESET;
      data_available_flag <= 1'b0;
      result <= RESULT_RESET;
      one_shot_req <= 1'b0;
      in_one_shot <= 1'b0;
      os_running <= 1'b0;
      start <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      rdata <= 16'h0000;
      irq <= 1'b0;
      state <= BUS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_word <= 16'h0000;
      byte_sel <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
      drive <= 1'b0;
      lockup_cnt <= 24'h00_0000;
      sda_o <= 1'b0;
    end else begin
      shutdown <= next_shutdown;
      res <= next_res;
      data_available_flag <= next_dav;
      result <= next_result;
      one_shot_req <= next_one_shot_req;
      in_one_shot <= next_in_one_shot;
      os_running <= next_os_running;
      start <= next_start;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      irq <= next_irq;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx_word <= next_tx_word;
      byte_sel <= next_byte_sel;
      rw <= next_rw;
      nack <= next_nack;
      drive <= next_drive;
      lockup_cnt <= next_lockup_cnt;
      sda_o <= 1'b0; // Open drain: only ever pulls low
    end
  end

  assign sda_oe_o = drive;
  assign reg_rdata_o = rdata;
  assign irq_o = irq;

endmodule : temp_sensor_smbus_core
`default_nettype wire

// ===== core/temp_sensor_pkg.sv
package temp_sensor_pkg;

  // Register offsets on the local register port (byte addresses)
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

  // Configuration register fields
  localparam int SHUTDOWN_BIT = 7;
  localparam int ONE_SHOT_BIT = 2;

  // Control/status register fields
  localparam int RES_HI_BIT = 6;
  localparam int RES_LO_BIT = 5;
  localparam int DATA_AVAILABLE_BIT = 0;

  // Interrupt status and mask layout
  localparam int IRQ_WIDTH = 3;
  localparam int IRQ_CONV_DONE_BIT = 0;
  localparam int IRQ_LOCKUP_BIT = 1;
  localparam int IRQ_ADDR_HIT_BIT = 2;

  // Reset and special values of the result word
  localparam logic [15:0] RESULT_RESET = 16'h7FFC;
  localparam logic [15:0] RESULT_ONE_SHOT = 16'h8000;
  localparam logic [15:0] LOW_BITS_11 = 16'h001F;
  localparam logic [1:0] RES_RESET = 2'h0;

  // Slave address: fixed upper nibble, variant bit, pin-selected pair
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [1:0] PIN_FLOAT = 2'h0;
  localparam logic [1:0] PIN_GROUND = 2'h1;
  localparam logic [1:0] PIN_SUPPLY = 2'h2;

  // Timing
  localparam int CLK_MHZ = 50;
  localparam int LOCKUP_MIN_US = 15000;
  localparam int LOCKUP_MAX_US = 45000;
  localparam int LOCKUP_TIME_US = (LOCKUP_MIN_US + LOCKUP_MAX_US) / 2;
  localparam int LOCKUP_CYCLES = LOCKUP_TIME_US * CLK_MHZ;
  localparam int GLITCH_NS = 60;
  localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_BASE_CYCLES = 1000;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ACK_ADDR = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_ACK_WRITE = 3'b100,
    BUS_READ = 3'b101,
    BUS_ACK_READ = 3'b110
  } bus_state_type;

endpackage : temp_sensor_pkg

// ===== core/conv_if.sv
`timescale 1ns/1ps
`default_nettype none
// Handshake between the conversion sequencer and the timing unit
interface conv_if;
  logic start;
  logic [1:0] res;
  logic busy;
  logic done;
  logic [15:0] value;
  modport ctl (output start, output res, input busy, input done,
               input value);
  modport cnv (input start, input res, output busy, output done,
               output value);
endinterface : conv_if
`default_nettype wire

// ===== core/line_filter.sv
`timescale 1ns/1ps
`default_nettype none
module line_filter #(
  parameter int STABLE = 3
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic line_i,
  output logic line_o
);
  logic sync1, sync2, level, next_level;
  logic [7:0] cnt, next_cnt;

  // A new level is taken only after it stays put for STABLE samples
  always_comb begin
    next_level = level;
    next_cnt = 8'h00;
    if (sync2 != level) begin
      next_cnt = cnt + 8'h01;
      if (cnt >= 8'(STABLE - 1)) begin
        next_level = sync2;
        next_cnt = 8'h00;
      end
    end
  end

  // Idle bus lines are high, so the filter starts high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      level <= 1'b1;
      cnt <= 8'h00;
    end else begin
      sync1 <= line_i;
      sync2 <= sync1;
      level <= next_level;
      cnt <= next_cnt;
    end
  end

  assign line_o = level;
endmodule : line_filter
`default_nettype wire

// ===== core/conv_unit.sv
`timescale 1ns/1ps
`default_nettype none
module conv_unit #(
  parameter int BASE_CYCLES = 1000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] sample_i,
  conv_if.cnv conv
);
  logic busy, next_busy, done, next_done;
  logic [23:0] cnt, next_cnt;
  logic [15:0] value, next_value;

  // Each step up in resolution doubles the conversion time
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_done = 1'b0;
    next_value = value;
    if (!busy && conv.start) begin
      next_busy = 1'b1;
      next_cnt = (24'(BASE_CYCLES) << conv.res) - 24'h00_0001;
    end else if (busy) begin
      if (cnt == 24'h00_0000) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_value = sample_i;
      end else begin
        next_cnt = cnt - 24'h00_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 24'h00_0000;
      value <= 16'h0000;
    end else begin
      busy <= next_busy;
      done <= next_done;
      cnt <= next_cnt;
      value <= next_value;
    end
  end

  assign conv.busy = busy;
  assign conv.done = done;
  assign conv.value = value;
endmodule : conv_unit
`default_nettype wire

// ===== sim/smbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Quarter of a 320 ns bus period: the slave answers about six clocks
  // after a filtered fall, so the low phase must outlast that
  task automatic q();
    repeat (4) @(posedge clk_i);
  endtask : q
  // Data set while clock is low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    r = sda_i;
    scl_o <= 1'b0;
    q();
  endtask : bit_io
  // Release both lines after a lockup
  task automatic idle();
    scl_o <= 1'b1;
    sda_low_o <= 1'b0;
    q();
    q();
  endtask : idle
  // Start once the data line reads high, or after 400 clocks at most
  task automatic start();
    for (int i = 0; i < 400 && sda_i !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    sda_low_o <= 1'b1;
    q();
    q();
    scl_o <= 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b0;
    q();
    q();
  endtask : stop
  // Eight bits MSB first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // Eight bits in, then our ack (low) or nack (released)
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : smbus_master_model
`default_nettype wire

// ===== sim/temp_sensor_smbus_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_smbus_core_props
  import temp_sensor_pkg::*;
#(
  parameter int LOCKUP_LIMIT = LOCKUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [1:0] addr_pin_i,
  input wire logic [15:0] sample_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic irq_o
);
  logic [1:0] res;
  logic shut;
  logic [7:0] scl_hist;
  int scl_low;
  // Shadows of resolution and shutdown, clock history and low run
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res <= RES_RESET;
      shut <= 1'b0;
      scl_hist <= 8'hFF;
      scl_low <= 0;
    end else begin
      if (reg_write_i && reg_addr_i == CONTROL_STATUS_OFFSET)
        res <= reg_wdata_i[RES_HI_BIT:RES_LO_BIT];
      if (reg_write_i && reg_addr_i == CONFIG_OFFSET)
        shut <= reg_wdata_i[SHUTDOWN_BIT];
      scl_hist <= {scl_hist[6:0], scl_i};
      scl_low <= scl_i ? 0 : scl_low + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence one_shot_req;
    reg_write_i && reg_addr_i == CONFIG_OFFSET &&
      reg_wdata_i[ONE_SHOT_BIT] && shut;
  endsequence
  sequence rd_result;
    reg_read_i && reg_addr_i == RESULT_OFFSET;
  endsequence
  sequence rd_status;
    reg_read_i && reg_addr_i == CONTROL_STATUS_OFFSET;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n_i |=> !sda_oe_o && !irq_o && reg_rdata_o == 16'h0000)
    else $error("outputs not quiet after reset");
  a_result_low_zero: assert property (
    rd_result |=> (reg_rdata_o & (LOW_BITS_11 >> res)) == 16'h0000)
    else $error("result bits below resolution not zero");
  a_res_readback: assert property (
    rd_status |=> reg_rdata_o[RES_HI_BIT:RES_LO_BIT] == res)
    else $error("resolution field read back wrong");
  a_one_shot_value: assert property (
    one_shot_req ##[1:8] rd_result |=> reg_rdata_o == RESULT_ONE_SHOT)
    else $error("result not 8000h during one-shot");
  a_one_shot_flag: assert property (
    one_shot_req ##[1:8] rd_status |=> !reg_rdata_o[DATA_AVAILABLE_BIT])
    else $error("available flag set during one-shot");
  a_drain_only: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_lockup_release: assert property (
    scl_low > LOCKUP_LIMIT + 16 |-> !sda_oe_o)
    else $error("data line held after lockup interval");
  a_drive_after_fall: assert property (
    $changed(sda_oe_o) |-> scl_hist[7:3] != 5'h1F)
    else $error("data drive changed without a filtered clock fall");
endmodule : temp_sensor_smbus_core_props
bind temp_sensor_smbus_core temp_sensor_smbus_core_props #(
  .LOCKUP_LIMIT(LOCKUP_LIMIT)
) props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_pin_i(addr_pin_i),
  .sample_i(sample_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import temp_sensor_pkg::*;
;
  localparam int LOCK = 200;
  localparam int CONV = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addr_pin = PIN_FLOAT;
  logic [15:0] sample = 16'hF39D;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic irq, sda_o, sda_oe, scl, sda_low;
  wire logic sda;
  int err_count = 0;
  int total_checks = 0;
  // Open-drain data wire with its external pull-up; the slave's level
  // only counts while it enables its driver
  assign sda = !sda_low && (sda_oe ? sda_o : 1'b1);
  initial begin
    forever #10 clk = ~clk;
  end
  temp_sensor_smbus_core #(
    .LOCKUP_LIMIT(LOCK), .CONV_CYCLES(CONV), .ADDR_VARIANT(1'b0)
  ) dut (
    .clk_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_pin_i(addr_pin),
    .sample_i(sample), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata), .irq_o(irq)
  );
  smbus_master_model m (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Register port; a spare edge after each write keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic t_reset();
    logic [15:0] d;
    rd(CONFIG_OFFSET, d);
    chk(d, 16'h0000);
    rd(CONTROL_STATUS_OFFSET, d);
    chk(d, 16'h0000);
    rd(RESULT_OFFSET, d);
    chk(d, 16'h7FE0);
    rd(8'h14, d);
    chk(d, 16'h0000);
    wr(8'h14, 16'hFFFF);
    rd(CONFIG_OFFSET, d);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_res();
    logic [15:0] d;
    for (int r = 0; r < 4; r++) begin
      wr(CONTROL_STATUS_OFFSET, 16'(r) << RES_LO_BIT);
      wr(IRQ_STATUS_OFFSET, 16'h0007);
      repeat ((CONV << r) * 2 + 20) @(posedge clk);
      rd(IRQ_STATUS_OFFSET, d);
      chk(d, 16'h0001);
      rd(CONTROL_STATUS_OFFSET, d);
      chk(d, (16'(r) << RES_LO_BIT) | 16'h0001);
      rd(RESULT_OFFSET, d);
      chk(d, 16'hF39D & ~(16'h001F >> r));
    end
    $display("test resolution done");
  endtask : t_res
  task automatic t_one_shot();
    logic [15:0] d;
    wr(CONTROL_STATUS_OFFSET, 16'h0000);
    wr(IRQ_MASK_OFFSET, 16'h0001);
    wr(CONFIG_OFFSET, 16'h0080);
    repeat (200) @(posedge clk);
    wr(IRQ_STATUS_OFFSET, 16'h0007);
    sample <= 16'h0C80;
    repeat (200) @(posedge clk);
    chk(irq, 1'b0);
    rd(RESULT_OFFSET, d);
    chk(d, 16'hF380);
    wr(CONFIG_OFFSET, 16'h0084);
    rd(RESULT_OFFSET, d);
    chk(d, 16'h8000);
    rd(CONTROL_STATUS_OFFSET, d);
    chk(d, 16'h0000);
    rd(CONFIG_OFFSET, d);
    chk(d, 16'h0080);
    for (int n = 0; n < 50 && d[0] !== 1'b1; n++) begin
      rd(CONTROL_STATUS_OFFSET, d);
    end
    chk(d, 16'h0001);
    rd(RESULT_OFFSET, d);
    chk(d, 16'h0C80);
    chk(irq, 1'b1);
    wr(IRQ_STATUS_OFFSET, 16'h0001);
    @(posedge clk);
    chk(irq, 1'b0);
    repeat (200) @(posedge clk);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 16'h0000);
    $display("test one-shot done");
  endtask : t_one_shot
  // Address, then a two-byte read of the result word
  task automatic frame(input logic [6:0] a, input logic ok);
    logic ack;
    logic [7:0] hi, lo;
    m.start();
    m.wr_byte({a, 1'b1}, ack);
    chk(ack, ok);
    if (ok) begin
      m.rd_byte(1'b0, hi);
      m.rd_byte(1'b1, lo);
      chk({hi, lo}, 16'h0C80);
    end
    m.stop();
  endtask : frame
  task automatic t_address();
    logic [15:0] d;
    wr(IRQ_STATUS_OFFSET, 16'h0007);
    for (int s = 0; s < 3; s++) begin
      addr_pin <= 2'(s);
      frame({4'h9, 1'b0, 2'(s)}, 1'b1);
    end
    frame(7'h4C, 1'b0);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 16'h0004);
    $display("test address done");
  endtask : t_address
  // Clock held low in mid-read until the slave gives up the line;
  // the clock went low four clocks before wr_byte returns
  task automatic t_lockup();
    logic ack;
    logic [15:0] d;
    wr(IRQ_STATUS_OFFSET, 16'h0007);
    m.start();
    m.wr_byte({7'h4A, 1'b1}, ack);
    repeat (LOCK - 30) @(posedge clk);
    chk(sda_oe, 1'b1);
    repeat (40) @(posedge clk);
    chk(sda_oe, 1'b0);
    chk(irq, 1'b0);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 16'h0006);
    m.idle();
    frame(7'h4A, 1'b1);
    $display("test lockup done");
  endtask : t_lockup
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_res();
    t_one_shot();
    t_address();
    t_lockup();
    print_verdict();
  end
  // Watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
